// File: kwf_pkg.sv
// Package for the key wake-up edge flag block: register map, widths, filter states.
// Assumes a byte-wide register port and a single bus clock.
package kwf_pkg;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_J_IE = 8'h2C;
    localparam logic [ADDR_W-1:0] ADDR_H_IE = 8'h2D;
    localparam logic [ADDR_W-1:0] ADDR_J_FLAGS = 8'h2E;
    localparam logic [ADDR_W-1:0] ADDR_H_FLAGS = 8'h2F;
    localparam logic [ADDR_W-1:0] ADDR_J_POL = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_H_POL = 8'h31;
    localparam logic [PORT_W-1:0] RST_BYTE = 8'h00;
    localparam logic [PORT_W-1:0] ALL_ONES = 8'hFF;
    // Filter oscillator period in bus clocks, last vote index and votes needed
    localparam int FILT_OSC_DIV = 4;
    localparam logic [1:0] VOTE_LAST = 2'h2;
    localparam logic [1:0] VOTE_NEED = 2'h2;

    typedef enum logic [1:0] {
        KWF_IDLE = 2'b00,
        KWF_VOTE = 2'b01,
        KWF_DONE = 2'b11
    } kwf_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [PORT_W-1:0] wdata;
        logic wr;
        logic rd;
    } kwf_bus_req_t;
endpackage

// File: kwf_stop_filter.sv
// Shared stop-mode majority filter with its own oscillator.
// Assumes the trigger input is already synchronised to the clock.
`timescale 1ns/1ns
`default_nettype none
module kwf_stop_filter
    import kwf_pkg::*;
#(
    parameter int OSC_DIV = FILT_OSC_DIV
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic stop_in,
    input wire logic trig_in,
    // Result
    output logic valid_out
);
    kwf_state_t state_ff, nxt_state;
    logic [$clog2(OSC_DIV)-1:0] osc_ff;
    logic [1:0] vote_ff, hits_ff;
    localparam int OSC_W = $clog2(OSC_DIV);
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);
    wire osc_tick = (osc_ff == OSC_LAST);
    wire vote_end = osc_tick && (vote_ff == VOTE_LAST);
    wire [1:0] hits_now = hits_ff + {1'b0, trig_in};

    // Oscillator starts on a triggering level
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            KWF_IDLE: if (stop_in && trig_in) nxt_state = KWF_VOTE;
            KWF_VOTE: if (!stop_in) nxt_state = KWF_IDLE;
                      else if (vote_end) nxt_state = KWF_DONE;
            KWF_DONE: nxt_state = KWF_IDLE;
            default: nxt_state = KWF_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= KWF_IDLE;
            osc_ff <= '0;
            vote_ff <= '0;
            hits_ff <= '0;
            valid_out <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            osc_ff <= (state_ff == KWF_VOTE && !osc_tick) ? osc_ff + 1'b1 : '0;
            if (state_ff != KWF_VOTE) begin
                vote_ff <= '0;
                hits_ff <= '0;
            end else if (osc_tick) begin
                vote_ff <= vote_ff + 2'h1;
                hits_ff <= hits_now;
            end
            // Two of three samples accept the pulse
            valid_out <= (state_ff == KWF_VOTE) && vote_end && (hits_now >= VOTE_NEED);
        end
    end
endmodule
`default_nettype wire

// File: kwf_wake_top.sv
// Key wake-up edge flags for ports J and H, registers and interrupt.
// Assumes pins are asynchronous; register port on the bus clock.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module kwf_wake_top
    import kwf_pkg::*;
#(
    parameter int W = PORT_W
) (
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic RESET_N_IN,
    // Pins and mode
    input wire logic [W-1:0] PORT_J_PINS_IN,
    input wire logic [W-1:0] PORT_H_PINS_IN,
    input wire logic STOP_MODE_IN,
    // Register port
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [W-1:0] RDATA_OUT,
    // Pull devices and interrupt
    output logic [W-1:0] PORT_J_PULLUP_OUT,
    output logic [W-1:0] PORT_J_PULLDOWN_OUT,
    output logic [W-1:0] PORT_H_PULLUP_OUT,
    output logic [W-1:0] PORT_H_PULLDOWN_OUT,
    output logic WAKE_IRQ_OUT,
    output logic WAKE_REQ_OUT
);
    localparam int N = 2 * W;
    kwf_bus_req_t req;
    assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

    logic [N-1:0] pol_ff, ie_ff, flag_ff, nxt_flag;
    logic [N-1:0] sa_ff, sb_ff, sc_ff, prev_ff;
    logic [W-1:0] rdata_ff;
    logic [N-1:0] stable, pins, active_lvl, run_edge, pol_chg, wr_pol, wr_ie, clr;
    logic [N-1:0] stop_edge, stop_hit_ff;
    logic filt_valid, stop_trig;

    assign pins = {PORT_H_PINS_IN, PORT_J_PINS_IN};

    // Register decode
    wire sel_j_ie = req.wr && req.addr == ADDR_J_IE;
    wire sel_h_ie = req.wr && req.addr == ADDR_H_IE;
    wire sel_j_fl = req.wr && req.addr == ADDR_J_FLAGS;
    wire sel_h_fl = req.wr && req.addr == ADDR_H_FLAGS;
    wire sel_j_po = req.wr && req.addr == ADDR_J_POL;
    wire sel_h_po = req.wr && req.addr == ADDR_H_POL;
    // Write one clears
    assign clr = {sel_h_fl ? req.wdata : RST_BYTE, sel_j_fl ? req.wdata : RST_BYTE};
    // Any time access
    assign wr_pol = {sel_h_po ? ALL_ONES : RST_BYTE, sel_j_po ? ALL_ONES : RST_BYTE};
    assign wr_ie = {sel_h_ie ? ALL_ONES : RST_BYTE, sel_j_ie ? ALL_ONES : RST_BYTE};
    wire [N-1:0] wdata2 = {req.wdata, req.wdata};
    wire [N-1:0] nxt_pol = (pol_ff & ~wr_pol) | (wdata2 & wr_pol);
    wire [N-1:0] nxt_ie = (ie_ff & ~wr_ie) | (wdata2 & wr_ie);

    wire [W-1:0] rd_mux =
        (req.addr == ADDR_J_IE) ? ie_ff[W-1:0] :
        (req.addr == ADDR_H_IE) ? ie_ff[N-1:W] :
        (req.addr == ADDR_J_FLAGS) ? flag_ff[W-1:0] :
        (req.addr == ADDR_H_FLAGS) ? flag_ff[N-1:W] :
        (req.addr == ADDR_J_POL) ? pol_ff[W-1:0] :
        (req.addr == ADDR_H_POL) ? pol_ff[N-1:W] : RST_BYTE;

    // Per-pin edge and pull logic
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            // Change counts once second and third stages agree
            assign stable[g] = (sb_ff[g] == sc_ff[g]) ? sc_ff[g] : prev_ff[g];
            // Triggering level: polarity 1 high, 0 low
            assign active_lvl[g] = stable[g] ~^ pol_ff[g];
            // Run mode compares with previous sample
            assign run_edge[g] = (stable[g] != prev_ff[g]) && active_lvl[g];
            // Polarity flip may make current level look like an edge
            assign pol_chg[g] = wr_pol[g] && (nxt_pol[g] != pol_ff[g]) &&
                                (stable[g] ~^ nxt_pol[g]);
            // Stop-mode edge of enabled pin, taken with the filter result
            assign stop_edge[g] = stop_hit_ff[g] && filt_valid;
        end
    endgenerate
    assign PORT_J_PULLUP_OUT = ~pol_ff[W-1:0];
    assign PORT_J_PULLDOWN_OUT = pol_ff[W-1:0];
    assign PORT_H_PULLUP_OUT = ~pol_ff[N-1:W];
    assign PORT_H_PULLDOWN_OUT = pol_ff[N-1:W];

    // Shared filter input: any enabled pin with a clear flag at its level
    assign stop_trig = |(active_lvl & ie_ff & ~flag_ff);
    wire [N-1:0] run_set = STOP_MODE_IN ? stop_edge : (run_edge | pol_chg);
    // Set wins over clear
    assign nxt_flag = (flag_ff & ~clr) | run_set;

    kwf_stop_filter #(.OSC_DIV(FILT_OSC_DIV)) u_filt (
        .clk_in(CLOCK_IN),
        .rst_n_in(RESET_N_IN),
        .stop_in(STOP_MODE_IN),
        .trig_in(stop_trig),
        .valid_out(filt_valid)
    ); // Close pulses merge in one vote window

    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            // Idle pin level under the reset pull-ups, so no false edge follows reset
            sa_ff <= '1;
            sb_ff <= '1;
            sc_ff <= '1;
            prev_ff <= '1;
            pol_ff <= '0;
            ie_ff <= '0;
            flag_ff <= '0;
            stop_hit_ff <= '0;
            rdata_ff <= RST_BYTE;
        end else begin
            sa_ff <= pins;
            sb_ff <= sa_ff;
            sc_ff <= sb_ff;
            prev_ff <= stable;
            pol_ff <= nxt_pol;
            ie_ff <= nxt_ie;
            flag_ff <= nxt_flag;
            stop_hit_ff <= STOP_MODE_IN ? ((stop_hit_ff | (active_lvl & ie_ff)) & ~stop_edge)
                                        : '0;
            rdata_ff <= req.rd ? rd_mux : RST_BYTE;
        end
    end
    assign RDATA_OUT = rdata_ff;

    // Shared interrupt of enabled flags
    assign WAKE_IRQ_OUT = |(flag_ff & ie_ff);
    // Unclocked wake path from enabled pins in stop
    wire [N-1:0] raw_lvl = pins ~^ pol_ff;
    assign WAKE_REQ_OUT = WAKE_IRQ_OUT | (STOP_MODE_IN & |(raw_lvl & ie_ff));

    // Assertions
    a_irq_gate: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        WAKE_IRQ_OUT == |(flag_ff & ie_ff)) else $error("irq gate wrong");
    a_w1c_clear: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (sel_j_fl && req.wdata[0] && !run_set[0]) |=> !flag_ff[0])
        else $error("flag not cleared");
    a_w0_keep: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (flag_ff[W] && !(sel_h_fl && req.wdata[0])) |=> flag_ff[W])
        else $error("flag lost");
    a_run_edge: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (!STOP_MODE_IN && run_edge[1]) |=> flag_ff[1])
        else $error("edge missed");
    a_fall_sets: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (!STOP_MODE_IN && !pol_ff[2] && $fell(stable[2]) && $stable(pol_ff[2])) |=> flag_ff[2])
        else $error("falling edge missed");
    a_rise_sets: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (!STOP_MODE_IN && pol_ff[W] && $rose(stable[W]) && $stable(pol_ff[W])) |=> flag_ff[W])
        else $error("rising edge missed");
    a_pull_sel: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        PORT_J_PULLDOWN_OUT == ~PORT_J_PULLUP_OUT) else $error("pull clash");
    a_stop_filter: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (STOP_MODE_IN && !filt_valid && !(|clr)) |=> flag_ff == $past(flag_ff))
        else $error("unfiltered set in stop");
    a_wake_path: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (STOP_MODE_IN && |(raw_lvl & ie_ff)) |-> WAKE_REQ_OUT)
        else $error("wake path dead");
    a_read_lat: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (req.rd && req.addr == ADDR_J_POL) |=> RDATA_OUT == $past(pol_ff[W-1:0]))
        else $error("read data wrong");
    // Pull devices follow polarity
    a_pull_j_up: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        PORT_J_PULLUP_OUT == ~pol_ff[W-1:0]) else $error("j pull-up wrong");
    a_pull_h_up: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        PORT_H_PULLUP_OUT == ~pol_ff[N-1:W]) else $error("h pull-up wrong");
    a_pull_h_sel: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        PORT_H_PULLDOWN_OUT == ~PORT_H_PULLUP_OUT) else $error("h pull clash");
    // Register writes and reads
    a_ie_j_write: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        sel_j_ie |=> ie_ff[W-1:0] == $past(req.wdata))
        else $error("j enable write lost");
    a_ie_h_write: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        sel_h_ie |=> ie_ff[N-1:W] == $past(req.wdata))
        else $error("h enable write lost");
    a_ie_hold: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (!sel_j_ie && !sel_h_ie) |=> ie_ff == $past(ie_ff))
        else $error("enable changed");
    a_pol_j_write: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        sel_j_po |=> pol_ff[W-1:0] == $past(req.wdata))
        else $error("j polarity write lost");
    a_pol_h_write: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        sel_h_po |=> pol_ff[N-1:W] == $past(req.wdata))
        else $error("h polarity write lost");
    a_flag_j_read: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (req.rd && req.addr == ADDR_J_FLAGS) |=> RDATA_OUT == $past(flag_ff[W-1:0]))
        else $error("j flag read wrong");
    a_flag_h_read: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (req.rd && req.addr == ADDR_H_FLAGS) |=> RDATA_OUT == $past(flag_ff[N-1:W]))
        else $error("h flag read wrong");
    a_rdata_idle: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        !req.rd |=> RDATA_OUT == RST_BYTE) else $error("read data lingers");
    // Flag set and clear
    a_j_edge_set: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (!STOP_MODE_IN && run_edge[W-1]) |=> flag_ff[W-1])
        else $error("j edge missed");
    a_h_edge_set: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (!STOP_MODE_IN && run_edge[N-1]) |=> flag_ff[N-1])
        else $error("h edge missed");
    a_pol_chg_set: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (!STOP_MODE_IN && pol_chg[0]) |=> flag_ff[0])
        else $error("polarity flag missed");
    a_no_spur_run: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (!STOP_MODE_IN && !run_edge[3] && !pol_chg[3]) |=> (!flag_ff[3] || $past(flag_ff[3])))
        else $error("spurious flag");
    a_w1c_h: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (sel_h_fl && req.wdata[W-1] && !run_set[N-1]) |=> !flag_ff[N-1])
        else $error("h flag not cleared");
    a_flag_sticky: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (flag_ff[5] && !clr[5]) |=> flag_ff[5]) else $error("flag dropped");
    a_set_wins: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (run_set[4] && clr[4]) |=> flag_ff[4]) else $error("clear beat set");
    // Stop-mode filter path
    a_stop_gated: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (STOP_MODE_IN && !filt_valid) |-> run_set == '0)
        else $error("set bypassed filter");
    a_stop_set: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (STOP_MODE_IN && stop_edge[0]) |=> flag_ff[0])
        else $error("filtered flag missed");
    a_hit_clear: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        !STOP_MODE_IN |=> stop_hit_ff == '0) else $error("hit kept in run");
    a_hit_enabled: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        (STOP_MODE_IN && active_lvl[0] && ie_ff[0]) |=> (stop_hit_ff[0] || $past(stop_edge[0])))
        else $error("enabled pin not seen");
    // Interrupt and wake request
    a_irq_low: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        ((flag_ff & ie_ff) == '0) |-> !WAKE_IRQ_OUT) else $error("irq without cause");
    a_req_irq: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
        WAKE_IRQ_OUT |-> WAKE_REQ_OUT) else $error("request misses irq");
    c_run_flag: cover property (@(posedge CLOCK_IN) !STOP_MODE_IN && run_edge[0]);
    c_clear_flag: cover property (@(posedge CLOCK_IN) |clr && |flag_ff);
    c_stop_wake: cover property (@(posedge CLOCK_IN) STOP_MODE_IN && filt_valid);
    c_irq: cover property (@(posedge CLOCK_IN) $rose(WAKE_IRQ_OUT));
    c_pol_flag: cover property (@(posedge CLOCK_IN) |pol_chg);
endmodule
`default_nettype wire

// File: kwf_pin_model.sv
// Pin partner: external switches on one 8-bit wake-up port.
// Assumes the block's pull outputs set the level of any released pin.
`timescale 1ns/1ns
`default_nettype none
module kwf_pin_model
    import kwf_pkg::*;
(
    // Switch control
    input wire logic [PORT_W-1:0] drive_en_in,
    input wire logic [PORT_W-1:0] drive_val_in,
    // Pull devices
    input wire logic [PORT_W-1:0] pullup_in,
    input wire logic [PORT_W-1:0] pulldown_in,
    // Pin levels
    output logic [PORT_W-1:0] pins_out
);
    // Driven pin shows drive_val_in; released pin follows its pull, else shows the inverse of drive_val_in
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (drive_en_in[i])
                pins_out[i] = drive_val_in[i];
            else if (pullup_in[i])
                pins_out[i] = 1'b1;
            else if (pulldown_in[i])
                pins_out[i] = 1'b0;
            else
                pins_out[i] = ~drive_val_in[i];
        end
    end
endmodule
`default_nettype wire

// File: kwf_wake_top_bench.sv
// Testbench for the key wake-up edge flag block.
// Assumes switch models on both ports and a one-cycle register port.
`timescale 1ns/1ns
`default_nettype none
module kwf_wake_top_bench;
    import kwf_pkg::*;
    logic clk, rst_n, stop, wr, rd, irq, req;
    logic [ADDR_W-1:0] addr;
    logic [PORT_W-1:0] wdata, rdata, pj, ph, pu_j, pd_j, pu_h, pd_h;
    logic [PORT_W-1:0] den_j, dval_j, den_h, dval_h;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    kwf_wake_top kwf_wake_top_i (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .PORT_J_PINS_IN(pj),
        .PORT_H_PINS_IN(ph), .STOP_MODE_IN(stop), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PORT_J_PULLUP_OUT(pu_j),
        .PORT_J_PULLDOWN_OUT(pd_j), .PORT_H_PULLUP_OUT(pu_h), .PORT_H_PULLDOWN_OUT(pd_h),
        .WAKE_IRQ_OUT(irq), .WAKE_REQ_OUT(req));
    kwf_pin_model kwf_pin_model_j_i (.drive_en_in(den_j), .drive_val_in(dval_j),
        .pullup_in(pu_j), .pulldown_in(pd_j), .pins_out(pj));
    kwf_pin_model kwf_pin_model_h_i (.drive_en_in(den_h), .drive_val_in(dval_h),
        .pullup_in(pu_h), .pulldown_in(pd_h), .pins_out(ph));
    always #4 clk = ~clk;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            $display("[ERR] timeout expected 20000 seen %0d", cyc);
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk8(input string n, input logic [PORT_W-1:0] e, input logic [PORT_W-1:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %b seen %b", n, e, g);
            fail_count++;
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [PORT_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [PORT_W-1:0] e, input string n);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk8(n, e, rdata);
    endtask
    task automatic t_reset();
        rd_chk(ADDR_J_POL, RST_BYTE, "j_pol");
        rd_chk(ADDR_J_IE, RST_BYTE, "j_ie");
        rd_chk(ADDR_H_IE, RST_BYTE, "h_ie");
        rd_chk(8'h40, RST_BYTE, "unmapped");
        chk8("j_pullup", ALL_ONES, pu_j);
        chk8("j_pulldown", RST_BYTE, pd_j);
        chk1("irq", 1'b0, irq);
    endtask
    task automatic t_run_j();
        @(posedge clk);
        den_j <= 8'h08;
        wait_cyc(8);
        rd_chk(ADDR_J_FLAGS, 8'h08, "j_flags");
        chk1("irq_masked", 1'b0, irq);
        wr_reg(ADDR_J_IE, 8'h08);
        wait_cyc(1);
        chk1("irq_on", 1'b1, irq);
        wr_reg(ADDR_J_FLAGS, 8'h00);
        rd_chk(ADDR_J_FLAGS, 8'h08, "j_keep");
        wr_reg(ADDR_J_FLAGS, 8'h08);
        wait_cyc(1);
        chk1("irq_off", 1'b0, irq);
        den_j <= 8'h00;
        wait_cyc(8);
        rd_chk(ADDR_J_FLAGS, 8'h00, "j_rise");
        wr_reg(ADDR_J_IE, 8'h00);
    endtask
    task automatic t_run_h();
        wr_reg(ADDR_H_POL, 8'h81);
        wait_cyc(8);
        chk8("h_pulldown", 8'h81, pd_h);
        chk8("h_pullup", 8'h7E, pu_h);
        wr_reg(ADDR_H_FLAGS, ALL_ONES);
        rd_chk(ADDR_H_FLAGS, 8'h00, "h_clear");
        den_h <= 8'h80;
        dval_h <= 8'h80;
        wait_cyc(8);
        rd_chk(ADDR_H_FLAGS, 8'h80, "h_flags");
        rd_chk(ADDR_J_FLAGS, 8'h00, "j_quiet");
        wr_reg(ADDR_H_FLAGS, 8'h80);
        den_h <= 8'h00;
        wait_cyc(8);
        rd_chk(ADDR_H_FLAGS, 8'h00, "h_fall");
        wr_reg(ADDR_H_POL, RST_BYTE);
        wait_cyc(8);
        wr_reg(ADDR_H_FLAGS, ALL_ONES);
    endtask
    task automatic t_stop();
        wr_reg(ADDR_J_IE, 8'h01);
        stop <= 1'b1;
        den_h <= 8'h04;
        den_j <= 8'h01;
        #1;
        chk1("req_pin", 1'b1, req);
        @(posedge clk);
        den_j <= 8'h00;
        wait_cyc(20);
        rd_chk(ADDR_J_FLAGS, 8'h00, "short");
        den_j <= 8'h01;
        wait_cyc(5);
        den_j <= 8'h00;
        wait_cyc(1);
        den_j <= 8'h01;
        wait_cyc(16);
        rd_chk(ADDR_J_FLAGS, 8'h01, "long");
        rd_chk(ADDR_H_FLAGS, 8'h00, "disabled");
        chk1("irq_stop", 1'b1, irq);
        den_j <= 8'h00;
        den_h <= 8'h00;
        stop <= 1'b0;
        wait_cyc(8);
        wr_reg(ADDR_J_FLAGS, ALL_ONES);
        wr_reg(ADDR_H_FLAGS, ALL_ONES);
    endtask
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {stop, wr, rd} = 3'h0;
        addr = 8'h00;
        wdata = 8'h00;
        {den_j, dval_j, den_h, dval_h} = 32'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_run_j();
        t_run_h();
        t_stop();
        print_verdict();
    end
endmodule
`default_nettype wire
